// ---- ssw_supervisor.sv ----
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor #(
  parameter int TICK_CYCLES     = ssw_pkg::TICK_CYCLES,
  parameter int DEBOUNCE_CYCLES = ssw_pkg::MR_DEB_CYCLES,
  parameter int CHANNELS        = 4
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write
  input  wire logic [3:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // asynchronous pins
  input  wire logic [CHANNELS-1:0]   supply_monitor_inputs,
  input  wire logic [4*CHANNELS-1:0] threshold_select_inputs,
  input  wire logic                  manual_reset_n,
  input  wire logic                  reset_disable_n,
  input  wire logic                  watchdog_kick,
  // supervisor outputs
  output logic                       reset_out_n,
  output logic                       watchdog_fail_n,
  output logic [CHANNELS-1:0]        channel_good_outputs
);
  localparam int NP = 5 * CHANNELS + 3;

  // two-stage synchronisers for every pin
  logic [NP-1:0] pin_a_r;  // first stage, read by pin_b_r only
  logic [NP-1:0] pin_b_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_a_r <= NP'(ssw_pkg::PIN_IDLE);  // released levels: no false disable or press
      pin_b_r <= NP'(ssw_pkg::PIN_IDLE);
    end else begin
      pin_a_r <= {threshold_select_inputs, supply_monitor_inputs,
                  watchdog_kick, reset_disable_n, manual_reset_n};
      pin_b_r <= pin_a_r;
    end
  end

  // synchronised views
  logic                  mr_s;
  logic                  reset_disable_n_s;
  logic                  kick_s;
  logic [CHANNELS-1:0]   above_s;
  logic [4*CHANNELS-1:0] code_s;
  assign mr_s    = pin_b_r[0];
  assign reset_disable_n_s  = pin_b_r[1];
  assign kick_s  = pin_b_r[2];
  assign above_s = pin_b_r[3 +: CHANNELS];
  assign code_s  = pin_b_r[3+CHANNELS +: 4*CHANNELS];

  // tick divider: one enable per timing base step
  logic [31:0] div_r;
  logic        tick;
  assign tick = (div_r == 32'(TICK_CYCLES - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) div_r <= '0;
    else div_r <= div_r + 32'h1;
  end

  // manual reset debounce: level must stand still to be taken
  logic        mr_deb_r;  // debounced level, 1 = released
  logic [31:0] deb_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mr_deb_r  <= 1'b1;
      deb_cnt_r <= '0;
    end else if (mr_s == mr_deb_r) begin
      deb_cnt_r <= '0;
    end else if (deb_cnt_r == 32'(DEBOUNCE_CYCLES - 1)) begin
      mr_deb_r  <= mr_s;
      deb_cnt_r <= '0;
    end else begin
      deb_cnt_r <= deb_cnt_r + 32'h1;
    end
  end

  // power-up configuration: convert then capture threshold codes
  ssw_pkg::ssw_cfg_t     cfg_r;
  logic [4:0]            conv_cnt_r;
  logic [4*CHANNELS-1:0] thr_code_r;
  logic [CHANNELS-1:0]   neg_adj;
  logic                  cfg_busy;
  assign cfg_busy = (cfg_r != ssw_pkg::CFG_RUN);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r      <= ssw_pkg::CFG_CONVERT;
      conv_cnt_r <= '0;
      thr_code_r <= '0;
    end else begin
      case (cfg_r)
        ssw_pkg::CFG_CONVERT: begin
          conv_cnt_r <= conv_cnt_r + 5'h1;
          if (conv_cnt_r == 5'(ssw_pkg::CONV_CYCLES - 1)) begin
            thr_code_r <= code_s;
            cfg_r      <= ssw_pkg::CFG_RUN;
          end
        end
        ssw_pkg::CFG_RUN: cfg_r <= ssw_pkg::CFG_RUN;
        default: cfg_r <= ssw_pkg::CFG_CONVERT;
      endcase
    end
  end

  // per-channel decode and real-time good level
  logic [CHANNELS-1:0] good;
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    assign neg_adj[i] = (thr_code_r[4*i +: 4] == ssw_pkg::NEG_ADJ_CODE);
    // negative adjust inverts the comparator sense
    assign good[i] = above_s[i] ^ neg_adj[i];
  end

  // channel outputs follow their comparator, no timeout
  always_ff @(posedge aclk) begin
    if (!aresetn) channel_good_outputs <= '0;
    else channel_good_outputs <= good;
  end

  // fault only counts once thresholds are known
  logic any_fault;
  assign any_fault = !cfg_busy && !(&good);

  // software registers: period pin modes and capacitor values
  logic [4:0]  ctrl_r;
  logic [15:0] cap_r;
  logic        rt_int;
  logic [1:0]  wt_mode;
  logic [1:0]  initial_timeout_select;
  assign rt_int  = ctrl_r[ssw_pkg::CTRL_RT_INT];
  assign wt_mode = ctrl_r[ssw_pkg::CTRL_WT_LSB +: 2];
  assign initial_timeout_select     = ctrl_r[ssw_pkg::CTRL_WDS_LSB +: 2];

  // timeout lengths in ticks, never below one
  logic [23:0] rt_cap_len;
  logic [23:0] rt_len;
  logic [23:0] wd_upper;
  logic [23:0] wd_init;
  assign rt_cap_len = 24'(cap_r[7:0]) * ssw_pkg::RT_UNIT_TICKS;
  always_comb begin
    rt_len = rt_int ? ssw_pkg::RT_INT_TICKS : rt_cap_len;
    if (rt_len == 24'h0) rt_len = 24'h1;
    case (wt_mode)
      ssw_pkg::WT_VCC:  wd_upper = ssw_pkg::WD_INT_TICKS;
      ssw_pkg::WT_OPEN: wd_upper = ssw_pkg::WD_OPEN_TICKS;
      default: wd_upper = 24'(cap_r[15:8]) * ssw_pkg::WD_UNIT_TICKS;
    endcase
    if (wd_upper == 24'h0) wd_upper = 24'h1;
    case (initial_timeout_select)
      ssw_pkg::WDS_LOW:  wd_init = wd_upper;
      ssw_pkg::WDS_OPEN: wd_init = wd_upper << ssw_pkg::INIT_SHIFT_OPEN;
      default:           wd_init = wd_upper << ssw_pkg::INIT_SHIFT_HIGH;
    endcase
  end

  // kick edge detector on the synchronised level
  logic kick_prev_r;
  logic kick_edge;
  always_ff @(posedge aclk) begin
    if (!aresetn) kick_prev_r <= 1'b0;
    else kick_prev_r <= kick_s;
  end
  assign kick_edge = kick_s ^ kick_prev_r;

  // watchdog counter state
  logic        rst_active_r;
  logic [23:0] wd_cnt_r;
  logic        first_r;  // still in the first period after a reset
  logic        wd_en;
  logic [23:0] wd_limit;
  logic        wd_fire;
  assign wd_en    = (wt_mode != ssw_pkg::WT_GND);
  assign wd_limit = first_r ? wd_init : wd_upper;
  // a kick in the expiring cycle saves the processor
  assign wd_fire = !rst_active_r && wd_en && tick && !kick_edge &&
                   (wd_cnt_r >= wd_limit - 24'h1);

  // watchdog period counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_cnt_r <= '0;
      first_r  <= 1'b1;
    end else if (rst_active_r) begin
      wd_cnt_r <= '0;
      first_r  <= 1'b1;
    end else if (kick_edge) begin
      wd_cnt_r <= '0;
      first_r  <= 1'b0;
    end else if (wd_fire) begin
      wd_cnt_r <= '0;
    end else if (wd_en && tick) begin
      wd_cnt_r <= wd_cnt_r + 24'h1;
    end
  end

  // fail latch: expiry sets, running kick or fault clears
  always_ff @(posedge aclk) begin
    if (!aresetn) watchdog_fail_n <= 1'b1;
    else if (wd_fire) watchdog_fail_n <= 1'b0;
    else if (any_fault) watchdog_fail_n <= 1'b1;
    // kicks inside the reset timeout are ignored here
    else if (kick_edge && !rst_active_r) watchdog_fail_n <= 1'b1;
  end

  // reset sequencer: held by causes, then one timed release
  logic        hold;
  logic [23:0] rst_cnt_r;
  logic        rst_active_nxt;
  logic [23:0] rst_cnt_nxt;
  assign hold = cfg_busy || !mr_deb_r || any_fault;
  always_comb begin
    rst_active_nxt = rst_active_r;
    rst_cnt_nxt    = rst_cnt_r;
    if (hold || wd_fire) begin
      rst_active_nxt = 1'b1;
      rst_cnt_nxt    = '0;
    end else if (rst_active_r && tick) begin
      if (rst_cnt_r >= rt_len - 24'h1) begin
        rst_active_nxt = 1'b0;
        rst_cnt_nxt    = '0;
      end else begin
        rst_cnt_nxt = rst_cnt_r + 24'h1;
      end
    end
  end

  // sequencer state and pin level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_active_r <= 1'b1;
      rst_cnt_r    <= '0;
      reset_out_n  <= 1'b0;
    end else begin
      rst_active_r <= rst_active_nxt;
      rst_cnt_r    <= rst_cnt_nxt;
      // margining: disable keeps the pin high
      reset_out_n  <= !rst_active_nxt || !reset_disable_n_s;
    end
  end

  // axi4-lite write path: address and data taken in any order
  logic       aw_got_r;
  logic       w_got_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       do_write;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign do_write      = aw_got_r && w_got_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else if (do_write) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // register update and write response
  logic aw_known;
  assign aw_known = (aw_addr_r[3:2] == 2'h0) || (aw_addr_r[3:2] == 2'h1) ||
                    (aw_addr_r[3:2] == 2'h2) || (aw_addr_r[3:2] == 2'h3);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r       <= ssw_pkg::CTRL_RST;
      cap_r        <= ssw_pkg::CAP_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ssw_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      // low address bits are ignored; status words are read-only
      s_axi_bresp  <= aw_known ? ssw_pkg::RESP_OKAY : ssw_pkg::RESP_SLVERR;
      if (aw_addr_r[3:2] == ssw_pkg::OFS_CTRL[3:2] && w_strb_r[0])
        ctrl_r <= w_data_r[4:0];
      if (aw_addr_r[3:2] == ssw_pkg::OFS_CAP[3:2]) begin
        if (w_strb_r[0]) cap_r[7:0]  <= w_data_r[7:0];
        if (w_strb_r[1]) cap_r[15:8] <= w_data_r[15:8];
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // axi4-lite read path: one cycle to data
  logic [31:0] rd_word;
  always_comb begin
    case (s_axi_araddr[3:2])
      ssw_pkg::OFS_CTRL[3:2]:   rd_word = {27'h0, ctrl_r};
      ssw_pkg::OFS_CAP[3:2]:    rd_word = {16'h0, cap_r};
      ssw_pkg::OFS_STATUS[3:2]:
        rd_word = {20'h0, neg_adj, good, first_r, watchdog_fail_n,
                   reset_out_n, rst_active_r};
      default:                  rd_word = {16'h0, thr_code_r};
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= ssw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= ssw_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks guard the sequencer, watchdog and channel outputs
  a_mr_pulls_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (!mr_deb_r && reset_disable_n_s) |=> !reset_out_n)
    else $error("manual reset did not pull reset low");

  a_release_timed: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(rst_active_r) |-> $past(tick) && !$past(hold) &&
      ($past(rst_cnt_r) >= $past(rt_len) - 24'h1))
    else $error("reset released before its timeout");

  a_reset_disable_n_holds_high: assert property (@(posedge aclk) disable iff (!aresetn)
    !reset_disable_n_s |=> reset_out_n)
    else $error("reset pulled low while disabled");

  a_fault_pulls_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (any_fault && reset_disable_n_s) |=> !reset_out_n ##0 rst_cnt_r == 24'h0)
    else $error("fault did not hold reset");

  a_good_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 channel_good_outputs == $past(above_s ^ neg_adj))
    else $error("channel output does not follow comparator");

  a_wd_idle_rst: assert property (@(posedge aclk) disable iff (!aresetn)
    rst_active_r |=> wd_cnt_r == 24'h0 && first_r)
    else $error("watchdog ran during reset");

  a_kick_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (kick_edge && !rst_active_r) |=> wd_cnt_r == 24'h0 && !first_r)
    else $error("kick did not clear watchdog");

  a_fire_resets: assert property (@(posedge aclk) disable iff (!aresetn)
    wd_fire |=> !watchdog_fail_n && rst_active_r ##1 (!reset_out_n || !reset_disable_n_s))
    else $error("expiry did not latch fail and reset");

  a_fail_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (rst_active_r && !watchdog_fail_n && !any_fault) |=> !watchdog_fail_n)
    else $error("fail cleared during reset timeout");

  a_uv_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (any_fault && !wd_fire) |=> watchdog_fail_n)
    else $error("fault did not clear watchdog fail");

  a_gnd_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    (wt_mode == ssw_pkg::WT_GND && watchdog_fail_n) |=> watchdog_fail_n)
    else $error("disabled watchdog latched a fail");

  // main scenarios
  c_wd_expiry: cover property (@(posedge aclk) disable iff (!aresetn)
    wd_fire);
  c_release: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(reset_out_n));
  c_kick_clear: cover property (@(posedge aclk) disable iff (!aresetn)
    !watchdog_fail_n ##1 watchdog_fail_n && !any_fault);
  c_reg_write: cover property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr_r[3:2] == 2'h0);
endmodule  // ssw_supervisor
`default_nettype wire

// ---- ssw_pkg.sv ----
`default_nettype none
// Notes on behaviour
// - manual reset low forces reset output low
// - release after timeout, all channels good
// - reset disable low keeps reset high
// - any fault holds reset, then delay
// - reset timeout 200ms or 12ms/nF
// - channel outputs follow comparators, no delay
// - watchdog runs only while reset high
// - either kick edge clears watchdog counter
// - expiry latches fail low, starts reset
// - fail clears on running kick or fault
// - kicks during reset timeout keep fail
// - watchdog reset lasts one reset timeout
// - untoggled after reset: reset again, fail low
// - fault during reset timeout clears fail
// - first period x1, x8, x64 by select
// - watchdog period 1.6s or 100ms/nF
// - period pin grounded disables watchdog
// - period pin open gives 2ms
// - reset low until configured, then timer
// - 4-bit code per channel at power-up
// - negative adjust faults above threshold
// - manual reset input is debounced
package ssw_pkg;
  // clock and timing base
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_US       = 100;
  localparam int TICK_CYCLES   = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int MR_DEB_US     = 20;
  localparam int MR_DEB_CYCLES = MR_DEB_US * 1000 / CLK_PERIOD_NS;
  localparam int CONV_CYCLES   = 16;
  // times as printed; capacitors are counted in 100pF units
  localparam int RT_INT_MS    = 200;
  localparam int RT_MS_PER_NF = 12;
  localparam int WD_INT_MS    = 1600;
  localparam int WD_MS_PER_NF = 100;
  localparam int WD_OPEN_MS   = 2;
  localparam logic [23:0] RT_INT_TICKS  = 24'(RT_INT_MS * 1000 / TICK_US);
  localparam logic [23:0] RT_UNIT_TICKS = 24'(RT_MS_PER_NF * 100 / TICK_US);
  localparam logic [23:0] WD_INT_TICKS  = 24'(WD_INT_MS * 1000 / TICK_US);
  localparam logic [23:0] WD_UNIT_TICKS = 24'(WD_MS_PER_NF * 100 / TICK_US);
  localparam logic [23:0] WD_OPEN_TICKS = 24'(WD_OPEN_MS * 1000 / TICK_US);
  // register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_CAP    = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_CODES  = 4'hc;
  // field positions
  localparam int CTRL_RT_INT = 0;
  localparam int CTRL_WT_LSB = 1;
  localparam int CTRL_WDS_LSB = 3;
  localparam int CAP_WT_LSB  = 8;
  // values after reset: internal timers, 1500pF caps
  localparam logic [4:0]  CTRL_RST = 5'h05;
  localparam logic [15:0] CAP_RST  = 16'h0f0f;
  localparam logic [1:0]  PIN_IDLE = 2'h3;  // manual reset and disable pins idle high
  // watchdog period pin modes
  localparam logic [1:0] WT_GND  = 2'h0;
  localparam logic [1:0] WT_OPEN = 2'h1;
  localparam logic [1:0] WT_VCC  = 2'h2;
  // initial timeout select levels
  localparam logic [1:0] WDS_LOW  = 2'h0;
  localparam logic [1:0] WDS_OPEN = 2'h1;
  localparam int INIT_SHIFT_OPEN = 3;
  localparam int INIT_SHIFT_HIGH = 6;
  // threshold code meaning negative adjust
  localparam logic [3:0] NEG_ADJ_CODE = 4'hf;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // configuration sequencer
  typedef enum logic {CFG_CONVERT, CFG_RUN} ssw_cfg_t;
endpackage
`default_nettype wire

// ---- ssw_proc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssw_proc_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench controls
  input  wire logic [3:0] rail_good,
  input  wire logic [3:0] neg_mask,
  input  wire logic       kick_en,
  input  wire logic       kick_now,
  input  wire logic [8:0] kick_gap,
  // supervisor side
  input  wire logic       reset_out_n,
  output var  logic [3:0] supply_monitor_inputs,
  output var  logic       watchdog_kick
);
  logic [8:0] gap_r; // cycles since the last kick

  // comparators: a negative adjust channel reads high when its rail is bad
  always_ff @(posedge aclk) begin
    supply_monitor_inputs <= rail_good ^ neg_mask;
  end

  // processor kicks only while out of reset, kick_now at any time; the bench may stop it to force expiry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r         <= 9'h000;
      watchdog_kick <= 1'b0;
    end else if (kick_now || (kick_en && reset_out_n && gap_r >= kick_gap)) begin
      gap_r         <= 9'h000;
      watchdog_kick <= !watchdog_kick;
    end else begin
      gap_r <= gap_r + 9'h001;
    end
  end
endmodule // ssw_proc_model
`default_nettype wire

// ---- ssw_supervisor_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor_tb;
  localparam int TK    = 4;     // shortened tick keeps the run short
  localparam int LIMIT = 80000; // run ceiling in cycles
  // clock, reset and register bus
  logic        aclk            = 1'b0;
  logic        aresetn         = 1'b0;
  logic [3:0]  s_axi_awaddr    = 4'h0;
  logic [3:0]  s_axi_araddr    = 4'h0;
  logic [3:0]  s_axi_wstrb     = 4'hf;
  logic [31:0] s_axi_wdata     = 32'h0;
  logic        s_axi_awvalid   = 1'b0;
  logic        s_axi_wvalid    = 1'b0;
  logic        s_axi_bready    = 1'b0;
  logic        s_axi_arvalid   = 1'b0;
  logic        s_axi_rready    = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // pins
  logic [15:0] threshold_select_inputs = 16'h000f;
  logic        manual_reset_n  = 1'b1;
  logic        reset_disable_n = 1'b1;
  logic [3:0]  supply_monitor_inputs, channel_good_outputs;
  logic        watchdog_kick, reset_out_n, watchdog_fail_n;
  // partner controls
  logic [3:0]  rail_good       = 4'h0;
  logic        kick_en         = 1'b0;
  logic        kick_now        = 1'b0;
  logic [8:0]  kick_gap        = 9'h064;
  // bookkeeping
  int          n_errors        = 0;
  int          cmp_count       = 0;
  int          cyc_n           = 0;
  logic [4:0]  modes [6]       = '{5'h06, 5'h0e, 5'h16, 5'h02, 5'h00, 5'h05};

  ssw_supervisor #(.TICK_CYCLES(TK), .DEBOUNCE_CYCLES(3)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .supply_monitor_inputs, .threshold_select_inputs,
    .manual_reset_n, .reset_disable_n, .watchdog_kick, .reset_out_n, .watchdog_fail_n,
    .channel_good_outputs);
  // channel 0 is strapped to negative adjust
  ssw_proc_model model (.aclk, .aresetn, .rail_good, .neg_mask(4'h1), .kick_en, .kick_now,
    .kick_gap, .reset_out_n, .supply_monitor_inputs, .watchdog_kick);

  always #2 aclk = ~aclk;

  // hang guard
  always @(posedge aclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == LIMIT) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // wait for an output level; lo above hi means it must never come within hi cycles
  task automatic wt(input int sel, input logic lvl, input int lo, input int hi, input string nm);
    int   n;
    logic ok;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while ((sel == 0 ? reset_out_n : watchdog_fail_n) !== lvl && n <= hi);
    ok = (lo > hi) ? (n > hi) : (n >= lo && n <= hi);
    cmp_count++;
    if (!ok) begin
      n_errors++;
      $display("[FAIL] %s expected %0d..%0d cycles seen %0d", nm, lo, hi, n);
    end
  endtask

  // handshakes held until taken; response ready held until answered
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        chk("bresp", 32'(ssw_pkg::RESP_OKAY), 32'(s_axi_bresp));
        s_axi_bready <= 1'b0;
      end
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) begin
        d = s_axi_rdata;
        chk("rresp", 32'(ssw_pkg::RESP_OKAY), 32'(s_axi_rresp));
        s_axi_rready <= 1'b0;
      end
    end while (s_axi_arvalid || s_axi_rready);
  endtask

  // kick toggle commanded regardless of reset state
  task automatic pulse;
    kick_now <= 1'b1;
    @(posedge aclk);
    kick_now <= 1'b0;
    @(posedge aclk);
  endtask

  // expected first-period length in cycles, capacitor of one unit
  function automatic int wd_cyc(input logic [4:0] c);
    int b;
    case (c[2:1])
      ssw_pkg::WT_OPEN: b = int'(ssw_pkg::WD_OPEN_TICKS);
      ssw_pkg::WT_VCC:  b = int'(ssw_pkg::WD_INT_TICKS);
      default:          b = int'(ssw_pkg::WD_UNIT_TICKS);
    endcase
    if (c[4:3] == ssw_pkg::WDS_OPEN)
      b = b << ssw_pkg::INIT_SHIFT_OPEN;
    else if (c[4:3] != ssw_pkg::WDS_LOW)
      b = b << ssw_pkg::INIT_SHIFT_HIGH;
    return b * TK;
  endfunction

  // expected reset timeout in cycles, capacitor of one unit
  function automatic int rt_cyc(input logic [4:0] c);
    return (c[0] ? int'(ssw_pkg::RT_INT_TICKS) : int'(ssw_pkg::RT_UNIT_TICKS)) * TK;
  endfunction

  initial begin
    logic [31:0] d;
    int          ch;
    void'($urandom(47));
    threshold_select_inputs <= {4'($urandom % 15), 4'($urandom % 15), 4'($urandom % 15), 4'hf};
    kick_gap <= 9'(50 + $urandom % 251);
    cyc(2);
    aresetn <= 1'b1;
    // register defaults, then short timers; reset held through configuration
    wt(0, 1'b1, 17, 16, "rst cfg");
    axi_rd(ssw_pkg::OFS_CTRL, d);
    chk("ctrl", 32'(ssw_pkg::CTRL_RST), d);
    axi_rd(ssw_pkg::OFS_CAP, d);
    chk("cap", 32'(ssw_pkg::CAP_RST), d);
    axi_wr(ssw_pkg::OFS_CTRL, 32'h06);
    axi_wr(ssw_pkg::OFS_CAP, 32'h0101);
    axi_rd(ssw_pkg::OFS_CAP, d);
    chk("cap wr", 32'h0101, d);
    cyc(16);
    axi_rd(ssw_pkg::OFS_CODES, d);
    chk("codes", {16'h0, threshold_select_inputs}, d);
    $display("test regs done");
    // rails come good, reset released after the timeout
    rail_good <= 4'hf;
    kick_en <= 1'b1;
    wt(0, 1'b1, 40, 64, "power up");
    chk("good", 32'hf, 32'(channel_good_outputs));
    ch = $urandom % 4;
    rail_good[ch] <= 1'b0;
    wt(0, 1'b0, 1, 8, "fault");
    cyc(2);
    chk("good one", 32'hf ^ (32'h1 << ch), 32'(channel_good_outputs));
    rail_good <= 4'hf;
    wt(0, 1'b1, 40, 64, "fault end");
    $display("test rails done");
    // manual reset: glitch ignored, held press resets
    manual_reset_n <= 1'b0;
    cyc(1);
    manual_reset_n <= 1'b1;
    wt(0, 1'b0, 21, 20, "glitch");
    manual_reset_n <= 1'b0;
    wt(0, 1'b0, 1, 12, "manual");
    manual_reset_n <= 1'b1;
    wt(0, 1'b1, 40, 70, "manual end");
    // margining: rails bad while disabled gives no reset
    reset_disable_n <= 1'b0;
    cyc(4);
    rail_good <= 4'h0;
    wt(0, 1'b0, 81, 80, "disable");
    rail_good <= 4'hf;
    cyc(80);
    reset_disable_n <= 1'b1;
    wt(0, 1'b0, 21, 20, "disable end");
    $display("test inputs done");
    // expiry, kick inside the reset timeout, repeat, fault clears fail
    kick_en <= 1'b0;
    wt(1, 1'b0, 1, 420, "expiry");
    wt(0, 1'b0, 1, 3, "wd reset");
    pulse();
    wt(0, 1'b1, 36, 52, "wd reset end");
    chk("fail held", 32'h0, 32'(watchdog_fail_n));
    wt(0, 1'b0, wd_cyc(5'h06) - 8, wd_cyc(5'h06) + 10, "again");
    chk("fail still", 32'h0, 32'(watchdog_fail_n));
    rail_good <= 4'h0;
    wt(1, 1'b1, 1, 8, "uv clear");
    rail_good <= 4'hf;
    wt(0, 1'b1, 40, 64, "uv end");
    // a kick after reset completes clears the fail; steady kicks avoid expiry
    wt(1, 1'b0, 1, 420, "expiry 2");
    wt(0, 1'b1, 40, 60, "release 2");
    pulse();
    wt(1, 1'b1, 1, 6, "kick clear");
    kick_gap <= 9'(50 + $urandom % 251);
    kick_en <= 1'b1;
    wt(1, 1'b0, 1201, 1200, "kicked");
    $display("test watchdog done");
    // each period mode and first-period stretch, entered through a manual reset
    foreach (modes[i]) begin
      manual_reset_n <= 1'b0;
      axi_wr(ssw_pkg::OFS_CTRL, 32'(modes[i]));
      kick_en <= 1'b0;
      cyc(8);
      manual_reset_n <= 1'b1;
      wt(0, 1'b1, rt_cyc(modes[i]) - 4, rt_cyc(modes[i]) + 22, "mode release");
      if (modes[i][2:1] == ssw_pkg::WT_GND)
        wt(0, 1'b0, 2001, 2000, "grounded");
      else if (wd_cyc(modes[i]) > 30000)
        wt(0, 1'b0, 2001, 2000, "internal");
      else
        wt(0, 1'b0, wd_cyc(modes[i]) - 8, wd_cyc(modes[i]) + 10, "first");
    end
    $display("test modes done");
    test_done();
  end
endmodule // ssw_supervisor_tb
`default_nettype wire
